/* File: hdl/dio_pkg.sv */
// constants and types shared by the digital port block
// assumes a 12-bit data-memory address and a one-clock access strobe
package dio_pkg;

   // data-memory locations of the port nibbles
   localparam logic [11:0] ADDR_FIRST_BIDIR  = 12'hff3;
   localparam logic [11:0] ADDR_SECOND_BIDIR = 12'hff6;
   localparam logic [11:0] ADDR_INPUT_ONLY   = 12'hff7;
   localparam logic [11:0] ADDR_SINGLE_BIT   = 12'hff8;

   // byte locations of the mode and pull-up registers (even addresses)
   localparam logic [11:0] ADDR_DIR_GROUP_A  = 12'hfe8;
   localparam logic [11:0] ADDR_DIR_GROUP_C  = 12'hfec;
   localparam logic [11:0] ADDR_PU_GROUP_A   = 12'hfdc;
   localparam logic [11:0] ADDR_PU_GROUP_B   = 12'hfde;

   // bank that opens the port area to nibble and byte accesses
   localparam logic [3:0]  PORT_BANK         = 4'hf;

   // values after reset
   localparam logic [7:0]  DIR_A_RESET       = 8'h00;
   localparam logic [7:0]  DIR_C_RESET       = 8'h00;
   localparam logic [7:0]  PU_A_RESET        = 8'h00;
   localparam logic [7:0]  PU_B_RESET        = 8'h00;
   localparam logic [3:0]  LATCH_RESET       = 4'h0;

   // field positions
   localparam int          DIR_A_FIRST_LSB   = 0;
   localparam int          DIR_A_SECOND_LSB  = 4;
   localparam int          DIR_C_SINGLE_BIT  = 0;
   localparam int          PU_A_FIRST_BIT    = 3;
   localparam int          PU_A_SECOND_BIT   = 6;
   localparam int          PU_B_SINGLE_BIT   = 0;

   // kinds of data-memory access
   typedef enum logic [3:0] {
      ACC_NONE,
      ACC_READ4,
      ACC_WRITE4,
      ACC_EXCHANGE,
      ACC_INCREMENT,
      ACC_READ8,
      ACC_WRITE8,
      ACC_BIT_TEST,
      ACC_BIT_SET,
      ACC_BIT_CLEAR,
      ACC_BIT_MOVE,
      ACC_BIT_TEST_CLEAR
   } access_t;

endpackage

/* File: hdl/port_slice.sv */
// one output latch group with its direction gating and pull-up gating
// assumes direction and pull-up enables come from registers outside
`timescale 1ns/10ps
module port_slice #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] dir,
   input  wire logic [W-1:0] pin_in,
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_val,
   input  wire logic         group_pullup,
   output logic      [W-1:0] readback,
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe_n,
   output logic      [W-1:0] pullup_en
);
   import dio_pkg::*;

   logic [W-1:0] latch_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_q <= LATCH_RESET[W-1:0];
      end else if (wr_en) begin
         latch_q <= wr_val;
      end
   end

   // driver follows the latch at once when the direction bit rises
   assign pin_out   = latch_q;
   assign pin_oe_n  = ~dir;
   assign readback  = (dir & latch_q) | (~dir & pin_in);
   // a driving pin never carries a pull-up
   assign pullup_en = {W{group_pullup}} & ~dir;
endmodule

/* File: hdl/access_unit.sv */
// result of one data-memory access on a port nibble
// assumes cur already holds pins for input bits and latch for output bits
`timescale 1ns/10ps
module access_unit (
   input  wire logic            op,
   input  dio_pkg::access_t     kind,
   input  wire logic [3:0]      cur,
   input  wire logic [3:0]      wdata,
   input  wire logic [1:0]      bit_idx,
   input  wire logic            cy_in,
   output logic      [3:0]      new_val,
   output logic                 we,
   output logic      [3:0]      rd,
   output logic                 skip
);
   import dio_pkg::*;

   logic [3:0] onehot;
   logic [3:0] incr;
   logic       cur_bit;

   assign onehot  = 4'h1 << bit_idx;
   assign incr    = cur + 4'h1;
   assign cur_bit = cur[bit_idx];

   always_comb begin
      new_val = cur;
      we      = 1'b0;
      rd      = 4'h0;
      skip    = 1'b0;
      if (op) begin
         case (kind)
            ACC_READ4: begin
               rd = cur;
            end
            ACC_WRITE4: begin
               new_val = wdata;
               we      = 1'b1;
            end
            ACC_EXCHANGE: begin
               rd      = cur;
               new_val = wdata;
               we      = 1'b1;
            end
            ACC_INCREMENT: begin
               new_val = incr;
               rd      = incr;
               skip    = (incr == 4'h0);
               we      = 1'b1;
            end
            ACC_BIT_TEST: begin
               rd = {3'b000, cur_bit};
            end
            // untouched bits take the read-back value
            ACC_BIT_SET: begin
               new_val = cur | onehot;
               we      = 1'b1;
            end
            ACC_BIT_CLEAR: begin
               new_val = cur & ~onehot;
               we      = 1'b1;
            end
            ACC_BIT_MOVE: begin
               new_val = cy_in ? (cur | onehot) : (cur & ~onehot);
               we      = 1'b1;
            end
            ACC_BIT_TEST_CLEAR: begin
               rd      = {3'b000, cur_bit};
               skip    = cur_bit;
               new_val = cur & ~onehot;
               we      = 1'b1;
            end
            default: begin
               rd = 4'h0;
            end
         endcase
      end
   end
endmodule

/* File: hdl/digital_io_ports.sv */
// memory-mapped digital ports: two 4-bit bidirectional, one 4-bit
// input-only and one 1-bit bidirectional, plus mode and pull-up registers
// assumes the cpu presents one access per mem_req pulse on clk
`timescale 1ns/10ps
module digital_io_ports #(
   parameter logic [3:0] INPUT_PULLUP_MASK = 4'h0
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            mem_req,
   input  dio_pkg::access_t     mem_kind,
   input  wire logic [11:0]     mem_addr,
   input  wire logic [7:0]      mem_wdata,
   input  wire logic [1:0]      mem_bit,
   input  wire logic            mem_bit_indirect,
   input  wire logic [3:0]      low_index,
   input  wire logic            carry_in,
   input  wire logic            bank_enable_flag,
   input  wire logic [3:0]      bank_select_value,
   output logic      [7:0]      mem_rdata,
   output logic                 mem_ack,
   output logic                 mem_hit,
   output logic                 mem_skip,
   input  wire logic [3:0]      first_bidir_port_in,
   output logic      [3:0]      first_bidir_port_out,
   output logic      [3:0]      first_bidir_port_oe_n,
   output logic      [3:0]      first_bidir_port_pullup,
   input  wire logic [3:0]      second_bidir_port_in,
   output logic      [3:0]      second_bidir_port_out,
   output logic      [3:0]      second_bidir_port_oe_n,
   output logic      [3:0]      second_bidir_port_pullup,
   input  wire logic [3:0]      input_only_port_in,
   output logic      [3:0]      input_only_port_pullup,
   input  wire logic            single_bit_port_in,
   output logic                 single_bit_port_out,
   output logic                 single_bit_port_oe_n,
   output logic                 single_bit_port_pullup
);
   import dio_pkg::*;

   // register state
   logic [7:0] port_direction_group_a_q;
   logic [7:0] port_direction_group_c_q;
   logic [7:0] pullup_select_group_a_q;
   logic [7:0] pullup_select_group_b_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       ack_q;
   logic       hit_q;
   logic       hit_d;
   logic       skip_q;

   // access classification
   wire        is_bit_op;
   wire        is_nib_op;
   wire        is_byte_op;
   wire        bank_open;
   wire [11:0] eff_addr;
   wire [1:0]  eff_bit;
   wire        port_reach;

   assign is_bit_op  = (mem_kind == ACC_BIT_TEST)
                     | (mem_kind == ACC_BIT_SET)
                     | (mem_kind == ACC_BIT_CLEAR)
                     | (mem_kind == ACC_BIT_MOVE)
                     | (mem_kind == ACC_BIT_TEST_CLEAR);
   assign is_nib_op  = (mem_kind == ACC_READ4)
                     | (mem_kind == ACC_WRITE4)
                     | (mem_kind == ACC_EXCHANGE)
                     | (mem_kind == ACC_INCREMENT);
   assign is_byte_op = (mem_kind == ACC_READ8)
                     | (mem_kind == ACC_WRITE8);

   // nibble and byte accesses see the port area with banking off or through bank 15
   assign bank_open = ~bank_enable_flag
                    | (bank_select_value == PORT_BANK);

   // indirect bit form takes low address bits and bit from the index
   assign eff_addr = (is_bit_op && mem_bit_indirect)
                   ? {mem_addr[11:2], low_index[3:2]}
                   : mem_addr;
   assign eff_bit  = (is_bit_op && mem_bit_indirect)
                   ? low_index[1:0]
                   : mem_bit;

   // bit forms bypass the bank mechanism entirely
   assign port_reach = mem_req
                     & (is_bit_op | (is_nib_op & bank_open));

   // port selects
   wire sel_first;
   wire sel_second;
   wire sel_input;
   wire sel_single;

   assign sel_first  = port_reach & (eff_addr == ADDR_FIRST_BIDIR);
   assign sel_second = port_reach & (eff_addr == ADDR_SECOND_BIDIR);
   assign sel_input  = port_reach & (eff_addr == ADDR_INPUT_ONLY);
   assign sel_single = port_reach & (eff_addr == ADDR_SINGLE_BIT);

   // byte register selects; odd addresses miss
   wire byte_ok;
   wire sel_dir_a;
   wire sel_dir_c;
   wire sel_pu_a;
   wire sel_pu_b;

   assign byte_ok   = mem_req & is_byte_op & bank_open;
   assign sel_dir_a = byte_ok & (mem_addr == ADDR_DIR_GROUP_A);
   assign sel_dir_c = byte_ok & (mem_addr == ADDR_DIR_GROUP_C);
   assign sel_pu_a  = byte_ok & (mem_addr == ADDR_PU_GROUP_A);
   assign sel_pu_b  = byte_ok & (mem_addr == ADDR_PU_GROUP_B);

   wire byte_wr;
   assign byte_wr = (mem_kind == ACC_WRITE8);

   // byte register write strobes
   wire wr_dir_a;
   wire wr_dir_c;
   wire wr_pu_a;
   wire wr_pu_b;

   assign wr_dir_a = sel_dir_a & byte_wr;
   assign wr_dir_c = sel_dir_c & byte_wr;
   assign wr_pu_a  = sel_pu_a & byte_wr;
   assign wr_pu_b  = sel_pu_b & byte_wr;

   // directions and pull-up group bits
   wire [3:0] dir_first;
   wire [3:0] dir_second;
   wire       dir_single;
   wire       pu_first;
   wire       pu_second;
   wire       pu_single;

   assign dir_first  = port_direction_group_a_q[DIR_A_FIRST_LSB +: 4];
   assign dir_second = port_direction_group_a_q[DIR_A_SECOND_LSB +: 4];
   assign dir_single = port_direction_group_c_q[DIR_C_SINGLE_BIT];
   assign pu_first   = pullup_select_group_a_q[PU_A_FIRST_BIT];
   assign pu_second  = pullup_select_group_a_q[PU_A_SECOND_BIT];
   assign pu_single  = pullup_select_group_b_q[PU_B_SINGLE_BIT];

   // read-back of each port
   wire [3:0] rb_first;
   wire [3:0] rb_second;
   wire [0:0] rb_single;
   wire [3:0] rb_input;
   wire [3:0] cur_nib;

   assign rb_input = input_only_port_in;

   // the access unit always sees the mode-dependent read-back value
   assign cur_nib = sel_first  ? rb_first
                  : sel_second ? rb_second
                  : sel_input  ? rb_input
                  : sel_single ? {3'b000, rb_single}
                  : 4'h0;

   // access result
   wire [3:0] alu_new;
   wire       alu_we;
   wire [3:0] alu_rd;
   wire       alu_skip;
   wire       any_port;

   assign any_port = sel_first | sel_second | sel_input | sel_single;

   access_unit u_access (
      .op      (any_port),
      .kind    (mem_kind),
      .cur     (cur_nib),
      .wdata   (mem_wdata[3:0]),
      .bit_idx (eff_bit),
      .cy_in   (carry_in),
      .new_val (alu_new),
      .we      (alu_we),
      .rd      (alu_rd),
      .skip    (alu_skip)
   );

   // latch write enables; the input-only nibble has no latch
   wire wr_first;
   wire wr_second;
   wire wr_single;

   assign wr_first  = sel_first & alu_we;
   assign wr_second = sel_second & alu_we;
   assign wr_single = sel_single & alu_we;

   port_slice #(
      .W (4)
   ) u_first (
      .clk          (clk),
      .rst          (rst),
      .dir          (dir_first),
      .pin_in       (first_bidir_port_in),
      .wr_en        (wr_first),
      .wr_val       (alu_new),
      .group_pullup (pu_first),
      .readback     (rb_first),
      .pin_out      (first_bidir_port_out),
      .pin_oe_n     (first_bidir_port_oe_n),
      .pullup_en    (first_bidir_port_pullup)
   );

   port_slice #(
      .W (4)
   ) u_second (
      .clk          (clk),
      .rst          (rst),
      .dir          (dir_second),
      .pin_in       (second_bidir_port_in),
      .wr_en        (wr_second),
      .wr_val       (alu_new),
      .group_pullup (pu_second),
      .readback     (rb_second),
      .pin_out      (second_bidir_port_out),
      .pin_oe_n     (second_bidir_port_oe_n),
      .pullup_en    (second_bidir_port_pullup)
   );

   wire [0:0] single_out;
   wire [0:0] single_oe_n;
   wire [0:0] single_pu;

   port_slice #(
      .W (1)
   ) u_single (
      .clk          (clk),
      .rst          (rst),
      .dir          (dir_single),
      .pin_in       (single_bit_port_in),
      .wr_en        (wr_single),
      .wr_val       (alu_new[0:0]),
      .group_pullup (pu_single),
      .readback     (rb_single),
      .pin_out      (single_out),
      .pin_oe_n     (single_oe_n),
      .pullup_en    (single_pu)
   );

   assign single_bit_port_out    = single_out[0];
   assign single_bit_port_oe_n   = single_oe_n[0];
   assign single_bit_port_pullup = single_pu[0];

   // fixed at build time, no register reaches it
   assign input_only_port_pullup = INPUT_PULLUP_MASK;

   // read data; direction registers are write-only and read as zero
   assign rdata_d = any_port ? {4'h0, alu_rd}
                  : (sel_pu_a && !byte_wr) ? pullup_select_group_a_q
                  : (sel_pu_b && !byte_wr) ? pullup_select_group_b_q
                  : 8'h00;

   assign hit_d = any_port | sel_dir_a | sel_dir_c | sel_pu_a | sel_pu_b;

   // direction registers; nibble and bit forms never reach them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_direction_group_a_q <= DIR_A_RESET;
      end else begin
         if (wr_dir_a) begin
            port_direction_group_a_q <= mem_wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_direction_group_c_q <= DIR_C_RESET;
      end else begin
         if (wr_dir_c) begin
            port_direction_group_c_q <= mem_wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pullup_select_group_a_q <= PU_A_RESET;
      end else begin
         if (wr_pu_a) begin
            pullup_select_group_a_q <= mem_wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pullup_select_group_b_q <= PU_B_RESET;
      end else begin
         if (wr_pu_b) begin
            pullup_select_group_b_q <= mem_wdata;
         end
      end
   end

   // answer one cycle after the access is taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= mem_req;
      end
   end

   // result fields hold until the next access is taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
         hit_q   <= 1'b0;
         skip_q  <= 1'b0;
      end else begin
         if (mem_req) begin
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
            skip_q  <= alu_skip;
         end
      end
   end

   assign mem_rdata = rdata_q;
   assign mem_ack   = ack_q;
   assign mem_hit   = hit_q;
   assign mem_skip  = skip_q;
endmodule

/* File: sim/dio_pin_model.sv */
// circuit outside one port: resolves each pin wire from all drivers
// assumes oe_n low while the block drives a pin
`timescale 1ns/10ps
module dio_pin_model #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] pu_on,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output logic      [W-1:0] pin
);
   logic [W-1:0] float_q = '0;

   // a released pin without pull-up wanders instead of holding its value
   always_ff @(posedge clk) begin
      float_q <= ~float_q;
   end

   assign pin = (~oe_n & out) | (oe_n & ext_en & ext_val)
              | (oe_n & ~ext_en & (pu_on | float_q));
endmodule

/* File: sim/dio_checker_assertions.sv */
// concurrent checks on the port block's access answers and pin controls
// assumes it is bound into digital_io_ports and sees only its ports
`timescale 1ns/10ps
module dio_checker #(
   parameter logic [3:0] INPUT_PULLUP_MASK = 4'h0
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        mem_req,
   input  dio_pkg::access_t mem_kind,
   input  wire logic [11:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic [1:0]  mem_bit,
   input  wire logic        mem_bit_indirect,
   input  wire logic        carry_in,
   input  wire logic        bank_enable_flag,
   input  wire logic [3:0]  bank_select_value,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ack,
   input  wire logic        mem_hit,
   input  wire logic [3:0]  first_bidir_port_in,
   input  wire logic [3:0]  first_bidir_port_out,
   input  wire logic [3:0]  first_bidir_port_oe_n,
   input  wire logic [3:0]  first_bidir_port_pullup,
   input  wire logic [3:0]  second_bidir_port_oe_n,
   input  wire logic [3:0]  second_bidir_port_pullup,
   input  wire logic [3:0]  input_only_port_pullup,
   input  wire logic        single_bit_port_out,
   input  wire logic        single_bit_port_oe_n,
   input  wire logic        single_bit_port_pullup
);
   import dio_pkg::*;
   wire logic bank_ok = !bank_enable_flag || bank_select_value == PORT_BANK;
   wire logic nib = mem_req && bank_ok && mem_addr == ADDR_FIRST_BIDIR;
   wire logic [3:0] wd_lo = mem_wdata[3:0];
   wire logic [3:0] wd_hi = mem_wdata[7:4];
   wire logic [3:0] mixed = (first_bidir_port_in & first_bidir_port_oe_n)
                          | (first_bidir_port_out & ~first_bidir_port_oe_n);

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_ack_next: assert property (mem_req |=> mem_ack)
      else $error("access not acknowledged next cycle");
   a_dir_drives: assert property (
      mem_req && bank_ok && mem_kind == ACC_WRITE8
         && mem_addr == ADDR_DIR_GROUP_A
      |=> first_bidir_port_oe_n == ~$past(wd_lo)
         && second_bidir_port_oe_n == ~$past(wd_hi))
      else $error("direction write not applied to drivers");
   a_write_latch: assert property (
      nib && mem_kind == ACC_WRITE4
      |=> first_bidir_port_out == $past(wd_lo))
      else $error("nibble write not latched");
   a_inc_output: assert property (
      nib && mem_kind == ACC_INCREMENT && first_bidir_port_oe_n == 4'h0
      |=> first_bidir_port_out == $past(first_bidir_port_out) + 4'h1)
      else $error("increment in output mode wrong");
   a_read_mixed: assert property (
      nib && mem_kind == ACC_READ4 |=> mem_rdata == {4'h0, $past(mixed)})
      else $error("read-back not pins or latch by direction");
   a_bit_move: assert property (
      mem_req && mem_kind == ACC_BIT_MOVE && !mem_bit_indirect
         && mem_bit == 2'h0 && mem_addr == ADDR_SINGLE_BIT
      |=> single_bit_port_out == $past(carry_in))
      else $error("bit move did not reach single-bit latch");
   a_pullup_gate: assert property (
      (first_bidir_port_pullup & ~first_bidir_port_oe_n) == 4'h0
      && (second_bidir_port_pullup & ~second_bidir_port_oe_n) == 4'h0
      && !(single_bit_port_pullup && !single_bit_port_oe_n))
      else $error("pull-up on an output pin");
   a_fixed_pullup: assert property (
      input_only_port_pullup == INPUT_PULLUP_MASK)
      else $error("input port pull-ups not the build option");
   a_reset_state: assert property (
      $past(rst) |-> first_bidir_port_oe_n == 4'hf && single_bit_port_oe_n
         && second_bidir_port_oe_n == 4'hf && first_bidir_port_out == 4'h0)
      else $error("state after reset wrong");
   a_unmapped: assert property (
      mem_req && mem_addr[11:8] != 4'hf |=> !mem_hit && mem_rdata == 8'h00)
      else $error("unmapped address answered");
endmodule

bind digital_io_ports dio_checker #(
   .INPUT_PULLUP_MASK(INPUT_PULLUP_MASK)
) u_dio_checker (
   .clk(clk), .rst(rst), .mem_req(mem_req), .mem_kind(mem_kind),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_bit(mem_bit),
   .mem_bit_indirect(mem_bit_indirect), .carry_in(carry_in),
   .bank_enable_flag(bank_enable_flag),
   .bank_select_value(bank_select_value), .mem_rdata(mem_rdata),
   .mem_ack(mem_ack), .mem_hit(mem_hit),
   .first_bidir_port_in(first_bidir_port_in),
   .first_bidir_port_out(first_bidir_port_out),
   .first_bidir_port_oe_n(first_bidir_port_oe_n),
   .first_bidir_port_pullup(first_bidir_port_pullup),
   .second_bidir_port_oe_n(second_bidir_port_oe_n),
   .second_bidir_port_pullup(second_bidir_port_pullup),
   .input_only_port_pullup(input_only_port_pullup),
   .single_bit_port_out(single_bit_port_out),
   .single_bit_port_oe_n(single_bit_port_oe_n),
   .single_bit_port_pullup(single_bit_port_pullup));

/* File: sim/digital_io_ports_tb_top.sv */
// self-checking bench for the digital port block
// assumes the pin model stands on both bidirectional nibbles and the bit
`timescale 1ns/10ps
module digital_io_ports_tb_top;
   import dio_pkg::*;
   localparam logic [3:0]  PU7 = 4'h5;
   localparam logic [10:0] DC  = 11'h100;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   access_t     kind = ACC_NONE;
   logic [11:0] addr = 12'h000;
   logic [7:0]  wd = 8'h00;
   logic [4:0]  bk = 5'h00;
   logic [3:0]  e2 = 4'hf;
   logic [3:0]  v1, v2, v7, w, x, y, n, p1i, p1o, p1e, p1u;
   logic [3:0]  p2i, p2o, p2e, p2u, p7u;
   logic [7:0]  rd;
   logic        ack, hit, skp, p8i, p8o, p8e, p8u;
   logic [10:0] note;
   logic [10:0] notes[$];
   int          seed = 46222;
   int          cmp_count = 0;
   int          n_mismatch = 0;

   always #25 clk = ~clk;

   digital_io_ports #(.INPUT_PULLUP_MASK(PU7)) DUT (
      .clk(clk), .rst(rst), .mem_req(req), .mem_kind(kind),
      .mem_addr(addr), .mem_wdata(wd), .mem_bit(wd[1:0]),
      .mem_bit_indirect(wd[6]), .low_index(wd[5:2]), .carry_in(wd[7]),
      .bank_enable_flag(bk[4]), .bank_select_value(bk[3:0]),
      .mem_rdata(rd), .mem_ack(ack), .mem_hit(hit), .mem_skip(skp),
      .first_bidir_port_in(p1i), .first_bidir_port_out(p1o),
      .first_bidir_port_oe_n(p1e), .first_bidir_port_pullup(p1u),
      .second_bidir_port_in(p2i), .second_bidir_port_out(p2o),
      .second_bidir_port_oe_n(p2e), .second_bidir_port_pullup(p2u),
      .input_only_port_in(v7), .input_only_port_pullup(p7u),
      .single_bit_port_in(p8i), .single_bit_port_out(p8o),
      .single_bit_port_oe_n(p8e), .single_bit_port_pullup(p8u));

   dio_pin_model #(.W(4)) pm1 (.clk(clk), .oe_n(p1e), .out(p1o),
      .pu_on(p1u), .ext_en(4'hf), .ext_val(v1), .pin(p1i));
   dio_pin_model #(.W(4)) pm2 (.clk(clk), .oe_n(p2e), .out(p2o),
      .pu_on(p2u), .ext_en(e2), .ext_val(v2), .pin(p2i));
   dio_pin_model #(.W(1)) pm8 (.clk(clk), .oe_n(p8e), .out(p8o),
      .pu_on(p8u), .ext_en(1'b1), .ext_val(v1[0]), .pin(p8i));

   task automatic tally(logic [10:0] g, logic [10:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t ns exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_rsp(logic [10:0] g, logic [10:0] e);
      tally(g, e);
   endtask
   task automatic chk_pin(logic [3:0] g, logic [3:0] e);
      tally({7'h0, g}, {7'h0, e});
   endtask
   function automatic logic [10:0] rv(logic [7:0] d, logic s = 1'b0);
      return {1'b1, s, 1'b1, d};
   endfunction
   // note: {data checked, skip, hit, data}; one access per clock
   task automatic acc(access_t k, logic [11:0] a, logic [7:0] d,
                      logic [10:0] e, logic [4:0] b = 5'h00);
      @(posedge clk);
      req <= 1'b1;
      kind <= k;
      addr <= a;
      wd <= d;
      bk <= b;
      notes.push_back(e);
   endtask
   task automatic settle();
      @(posedge clk);
      req <= 1'b0;
      @(negedge clk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1) begin
         if (notes.size() == 0) begin
            chk_rsp(11'h7ff, 11'h000);
         end else begin
            note = notes.pop_front();
            chk_rsp({note[10], skp, hit, note[10] ? rd : note[7:0]},
                    note);
         end
      end
   end

   initial begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      v1 = 4'($random(seed));
      v2 = 4'($random(seed));
      v7 = 4'($random(seed));
      w = 4'($random(seed));
      x = 4'($random(seed));
      y = 4'($random(seed));
      n = v2 + 4'h1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk_pin(p1o, LATCH_RESET);
      chk_pin(p1e & p2e, 4'hf);
      chk_pin({p8e, p8o, p1u[0], p2u[0]}, 4'h8);
      acc(ACC_READ8, ADDR_PU_GROUP_A, 8'h00, rv(PU_A_RESET));
      acc(ACC_READ8, ADDR_DIR_GROUP_A, 8'h00, rv(DIR_A_RESET));
      acc(ACC_WRITE4, ADDR_FIRST_BIDIR, {4'h0, w}, DC);
      acc(ACC_READ4, ADDR_FIRST_BIDIR, 8'h00, rv({4'h0, v1}));
      acc(ACC_READ4, ADDR_INPUT_ONLY, 8'h00, rv({4'h0, v7}));
      settle();
      chk_pin(p1o, w);
      chk_pin(p1e, 4'hf);
      $display("test done: reset and input mode");
      acc(ACC_WRITE8, ADDR_DIR_GROUP_A, 8'h0f, DC);
      acc(ACC_READ4, ADDR_FIRST_BIDIR, 8'h00, rv({4'h0, w}));
      acc(ACC_EXCHANGE, ADDR_FIRST_BIDIR, {4'h0, x}, rv({4'h0, w}));
      acc(ACC_EXCHANGE, ADDR_SECOND_BIDIR, {4'h0, y}, rv({4'h0, v2}));
      settle();
      chk_pin(p2e, 4'hf);
      chk_pin(p1e, 4'h0);
      chk_pin(p1i, x);
      chk_pin(p2o, y);
      $display("test done: direction and exchange");
      acc(ACC_WRITE4, ADDR_FIRST_BIDIR, 8'h0f, DC);
      acc(ACC_INCREMENT, ADDR_FIRST_BIDIR, 8'h00, rv(8'h00, 1'b1));
      acc(ACC_INCREMENT, ADDR_SECOND_BIDIR, 8'h00,
          rv({4'h0, n}, n == 4'h0));
      settle();
      chk_pin(p1i, 4'h0);
      chk_pin(p2o, n);
      $display("test done: increment");
      acc(ACC_BIT_SET, 12'hff0, 8'h78, DC, 5'h13);
      acc(ACC_BIT_TEST_CLEAR, ADDR_FIRST_BIDIR, 8'h02,
          rv(8'h01, 1'b1), 5'h13);
      acc(ACC_BIT_SET, ADDR_SECOND_BIDIR, 8'h03, DC, 5'h13);
      acc(ACC_BIT_TEST, ADDR_SECOND_BIDIR, 8'h01,
          rv({7'h0, v2[1]}), 5'h13);
      acc(ACC_WRITE8, ADDR_DIR_GROUP_C, 8'h01, DC);
      acc(ACC_BIT_MOVE, ADDR_SINGLE_BIT, 8'h80, DC, 5'h13);
      settle();
      chk_pin(p1o, 4'h0);
      chk_pin(p2o, v2 | 4'h8);
      chk_pin({2'h0, p8e, p8i}, 4'h1);
      $display("test done: bit accesses");
      acc(ACC_BIT_CLEAR, ADDR_SINGLE_BIT, 8'h00, DC, 5'h13);
      acc(ACC_WRITE8, ADDR_PU_GROUP_A, 8'h48, DC);
      acc(ACC_WRITE8, ADDR_PU_GROUP_B, 8'h01, DC);
      e2 <= 4'h0;
      acc(ACC_READ8, ADDR_PU_GROUP_A, 8'h00, rv(8'h48));
      acc(ACC_READ4, ADDR_SECOND_BIDIR, 8'h00, rv(8'h0f));
      settle();
      chk_pin(p1u, 4'h0);
      chk_pin({p8u, p8o, 2'h0}, 4'h0);
      chk_pin(p2u, 4'hf);
      chk_pin(p7u, PU7);
      acc(ACC_WRITE8, ADDR_DIR_GROUP_C, 8'h00, DC);
      settle();
      chk_pin({3'h0, p8u}, 4'h1);
      $display("test done: pull-ups");
      acc(ACC_WRITE4, ADDR_FIRST_BIDIR, {4'h0, w}, 11'h400, 5'h13);
      acc(ACC_WRITE4, ADDR_SECOND_BIDIR, {4'h0, x}, DC, 5'h1f);
      acc(ACC_READ4, 12'h100, 8'h00, 11'h400);
      settle();
      chk_pin(p1o, 4'h0);
      chk_pin(p2o, x);
      $display("test done: bank and address decode");
      settle();
      settle();
      chk_rsp(11'(notes.size()), 11'h000);
      complete_run();
   end
endmodule
